//--- logic/ssalu_pkg.sv
package ssalu_pkg;
	localparam int WORD_W = 24;
	localparam int PAIR_W = 48;
	localparam int IDX_W  = 15;
	localparam int FRAC_W = 36;
	localparam int EXP_W  = 11;
	// Opcodes, six bits
	localparam logic [5:0] OP_SHIFT_SINGLE   = 6'h0a;
	localparam logic [5:0] OP_SHIFT_PAIR     = 6'h0b;
	localparam logic [5:0] OP_XOR_IMMEDIATE  = 6'h0e;
	localparam logic [5:0] OP_AND_IMMEDIATE  = 6'h0f;
	localparam logic [5:0] OP_ADD_ACC        = 6'h18;
	localparam logic [5:0] OP_SUB_ACC        = 6'h19;
	localparam logic [5:0] OP_DOUBLE_ADD     = 6'h1a;
	localparam logic [5:0] OP_DOUBLE_SUB     = 6'h1b;
	localparam logic [5:0] OP_REPLACE_ADD    = 6'h1c;
	localparam logic [5:0] OP_SINGLE_MUL     = 6'h28;
	localparam logic [5:0] OP_SINGLE_DIV     = 6'h29;
	localparam logic [5:0] OP_DOUBLE_MUL     = 6'h2e;
	localparam logic [5:0] OP_DOUBLE_DIV     = 6'h2f;
	localparam logic [5:0] OP_FLOAT_ADD      = 6'h30;
	localparam logic [5:0] OP_FLOAT_SUB      = 6'h31;
	localparam logic [5:0] OP_FLOAT_MUL      = 6'h32;
	localparam logic [5:0] OP_FLOAT_DIV      = 6'h33;
	// Designator field of the immediate logical group
	localparam logic [2:0] DESIG_ACC_SEXT = 3'h4;
	localparam logic [2:0] DESIG_AUX_SEXT = 3'h5;
	localparam logic [2:0] DESIG_ACC_ZEXT = 3'h6;
	localparam logic [2:0] DESIG_AUX_ZEXT = 3'h7;
	// Preload register select codes
	localparam logic [2:0] SEL_ACC    = 3'h0;
	localparam logic [2:0] SEL_AUX    = 3'h1;
	localparam logic [2:0] SEL_EXT_HI = 3'h2;
	localparam logic [2:0] SEL_EXT_LO = 3'h3;
	localparam logic [2:0] SEL_IDX1   = 3'h4;
	localparam logic [2:0] SEL_IDX2   = 3'h5;
	localparam logic [2:0] SEL_IDX3   = 3'h6;
	// Scale limit and float exponent bias
	localparam logic [5:0]  SCALE_LIMIT = 6'h30;
	localparam logic [10:0] EXP_BIAS    = 11'h400;
	// Reset values
	localparam logic [23:0] WORD_RST = 24'h000000;
	localparam logic [47:0] EXT_RST  = 48'h000000000000;
	localparam logic [14:0] IDX_RST  = 15'h0000;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SCALE  = 2'b01,
		ST_DIVIDE = 2'b10
	} state_type;
endpackage : ssalu_pkg

//--- logic/register_shifter.sv
`timescale 1ns/10ps
module register_shifter #(
	parameter int W = 24
) (
	// Operand and control
	input  wire logic [W-1:0] data_in,
	input  wire logic         left_in,
	input  wire logic [5:0]   mag_in,
	// Result
	output logic      [W-1:0] data_out
);
	localparam logic [6:0] W7 = 7'(W);
	// Counts past one turn wrap, so W places is no change
	wire [6:0]     rot_amt = {1'b0, mag_in} % W7;
	wire [2*W-1:0] dbl     = {data_in, data_in} << rot_amt;
	// Arithmetic shift saturates to all sign bits for large counts
	wire [W-1:0]   right   = W'($signed(data_in) >>> mag_in);
	assign data_out = left_in ? dbl[2*W-1:W] : right;
endmodule : register_shifter

//--- logic/magnitude_divider.sv
`timescale 1ns/10ps
module magnitude_divider #(
	parameter int W = 48
) (
	// Clock and reset
	input  wire logic           clk_in,
	input  wire logic           rst_n_in,
	// Request
	input  wire logic           start_in,
	input  wire logic [2*W-1:0] dividend_in,
	input  wire logic [W-1:0]   divisor_in,
	// Answer
	output logic                busy_out,
	output logic                done_out,
	output logic      [2*W-1:0] quot_out,
	output logic      [W-1:0]   rem_out
);
	localparam int CW = $clog2(2*W+1);
	logic [W-1:0]   dvsr_ff;
	logic [W-1:0]   rem_ff;
	logic [2*W-1:0] quot_ff;
	logic [CW-1:0]  cnt_ff;
	logic           busy_ff;
	logic           done_ff;
	// One restoring step per clock; slow but small
	wire [W:0]   shifted = {rem_ff, quot_ff[2*W-1]};
	wire [W+1:0] trial   = {1'b0, shifted} - {2'b00, dvsr_ff};
	wire         borrow  = trial[W+1];
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dvsr_ff <= '0;
			rem_ff  <= '0;
			quot_ff <= '0;
			cnt_ff  <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start_in) begin
				dvsr_ff <= divisor_in;
				rem_ff  <= '0;
				quot_ff <= dividend_in;
				cnt_ff  <= CW'(2*W);
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				rem_ff  <= borrow ? shifted[W-1:0] : trial[W-1:0];
				quot_ff <= {quot_ff[2*W-2:0], ~borrow};
				cnt_ff  <= cnt_ff - CW'(1);
				if (cnt_ff == CW'(1)) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
		end
	end
	assign busy_out = busy_ff;
	assign done_out = done_ff;
	assign quot_out = quot_ff;
	assign rem_out  = rem_ff;
endmodule : magnitude_divider

//--- logic/shift_scale_arith_logic_unit.sv
`timescale 1ns/10ps
module shift_scale_arith_logic_unit (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Instruction request from sequencer
	input  wire logic        start_in,
	input  wire logic [5:0]  op_in,
	input  wire logic [2:0]  desig_in,
	input  wire logic [14:0] field_in,
	input  wire logic [23:0] oper_hi_in,
	input  wire logic [23:0] oper_lo_in,
	// Register preload
	input  wire logic        preload_in,
	input  wire logic [2:0]  preload_sel_in,
	input  wire logic [23:0] preload_data_in,
	// Status
	output logic             busy_out,
	output logic             done_out,
	output logic             div_fault_out,
	// Storage write-back
	output logic             store_valid_out,
	output logic      [23:0] store_data_out,
	// Register contents
	output logic      [23:0] acc_out,
	output logic      [23:0] aux_out,
	output logic      [47:0] ext_out,
	output logic      [14:0] idx1_out,
	output logic      [14:0] idx2_out,
	output logic      [14:0] idx3_out
);
	ssalu_pkg::state_type state_ff, nxt_state;
	logic [23:0] acc_ff, nxt_acc, aux_ff, nxt_aux;
	logic [47:0] ext_ff, nxt_ext;
	logic [14:0] idx_ff [3];
	logic [14:0] nxt_idx [3];
	logic [5:0]  cnt_ff, nxt_cnt;
	logic [5:0]  op_ff, nxt_op;
	logic [1:0]  b_ff, nxt_b;
	logic [23:0] k_ff, nxt_k;
	logic        qneg_ff, nxt_qneg, rneg_ff, nxt_rneg;
	logic [10:0] fexp_ff, nxt_fexp;
	logic        done_ff, nxt_done, fault_ff, nxt_fault, busy_ff;
	logic        store_ff, nxt_store;
	logic [23:0] store_data_ff, nxt_store_data;

	function automatic logic [23:0] oc_add24(input logic [23:0] x, input logic [23:0] y);
		logic [24:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[23:0] + {23'h000000, s[24]};
	endfunction : oc_add24
	function automatic logic [47:0] oc_add48(input logic [47:0] x, input logic [47:0] y);
		logic [48:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[47:0] + {47'h0, s[48]};
	endfunction : oc_add48
	function automatic logic [5:0] lead_zeros(input logic [35:0] v);
		logic [5:0] n;
		logic       hit;
		n = 6'h24;
		hit = 1'b0;
		for (int i = 35; i >= 0; i--) begin
			if (v[i] && !hit) begin
				n = 6'(35 - i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction : lead_zeros

	// Operand views
	wire        idle     = state_ff == ssalu_pkg::ST_IDLE;
	wire        go       = start_in && idle;
	wire [47:0] pair     = {acc_ff, aux_ff};
	wire [47:0] mem48    = {oper_hi_in, oper_lo_in};
	wire [1:0]  bsel     = desig_in[1:0];
	wire [1:0]  bidx     = bsel - 2'h1;
	wire [14:0] idx_sel  = (bsel == 2'h0) ? 15'h0000 : idx_ff[bidx];

	wire [23:0] k_sext   = {{9{field_in[14]}}, field_in};
	wire [23:0] b_sext   = {{9{idx_sel[14]}}, idx_sel};
	wire [23:0] eff_k    = oc_add24(k_sext, b_sext);
	// only bit 23 and bits 0-5 matter
	wire        sh_left  = ~eff_k[23];
	wire [5:0]  sh_mag   = sh_left ? eff_k[5:0] : ~eff_k[5:0];
	// desig bit 2 picks auxiliary over accumulator
	wire [23:0] sh_src   = desig_in[2] ? aux_ff : acc_ff;
	wire [23:0] sh_one;
	wire [47:0] sh_two;

	register_shifter #(.W(24)) single_shift (
		.data_in  (sh_src),
		.left_in  (sh_left),
		.mag_in   (sh_mag),
		.data_out (sh_one)
	);
	register_shifter #(.W(48)) pair_shift (
		.data_in  (pair),
		.left_in  (sh_left),
		.mag_in   (sh_mag),
		.data_out (sh_two)
	);

	// Fixed-point sums
	// adders
	wire [23:0] sum_acc  = oc_add24(acc_ff, oper_hi_in);
	wire [23:0] diff_acc = oc_add24(acc_ff, ~oper_hi_in);
	wire [47:0] sum_pair = oc_add48(pair, mem48);
	wire [47:0] dif_pair = oc_add48(pair, ~mem48);

	// Sign-magnitude views for multiply and divide
	wire [23:0] acc_mag  = acc_ff[23] ? ~acc_ff : acc_ff;
	wire [23:0] mem_mag  = oper_hi_in[23] ? ~oper_hi_in : oper_hi_in;
	wire [47:0] pair_mag = pair[47] ? ~pair : pair;
	wire [47:0] m48_mag  = mem48[47] ? ~mem48 : mem48;
	wire [95:0] trip     = {acc_ff, aux_ff, ext_ff};
	wire [95:0] trip_mag = trip[95] ? ~trip : trip;
	wire [47:0] mul1_mag = 48'(acc_mag[22:0] * mem_mag[22:0]);
	wire [47:0] mul1     = (acc_ff[23] ^ oper_hi_in[23]) ? ~mul1_mag : mul1_mag;
	wire [95:0] mul2_mag = 96'(pair_mag[46:0] * m48_mag[46:0]);
	wire [95:0] mul2     = (pair[47] ^ mem48[47]) ? ~mul2_mag : mul2_mag;

	// Float unpack: complemented word when negative
	wire        fa_neg   = pair[47];
	wire [47:0] fa_w     = fa_neg ? ~pair : pair;
	wire [10:0] fa_exp   = fa_w[46:36];
	wire [35:0] fa_man   = fa_w[35:0];
	wire        fb_neg   = mem48[47] ^ (op_in == ssalu_pkg::OP_FLOAT_SUB);
	wire [47:0] fb_w     = mem48[47] ? ~mem48 : mem48;
	wire [10:0] fb_exp   = fb_w[46:36];
	wire [35:0] fb_man   = fb_w[35:0];

	// align smaller operand, keep lost bits
	wire        a_big    = fa_exp >= fb_exp;
	wire [10:0] ediff    = a_big ? fa_exp - fb_exp : fb_exp - fa_exp;
	wire [35:0] big_man  = a_big ? fa_man : fb_man;
	wire [35:0] sml_man  = a_big ? fb_man : fa_man;
	wire        big_neg  = a_big ? fa_neg : fb_neg;
	wire        sml_neg  = a_big ? fb_neg : fa_neg;
	wire [10:0] big_exp  = a_big ? fa_exp : fb_exp;
	wire [71:0] aligned  = {sml_man, 36'h0} >> ediff;
	wire [35:0] sml_al   = aligned[71:36];
	wire        same_sg  = big_neg == sml_neg;
	wire        big_ge   = big_man >= sml_al;
	wire [36:0] fsum     = same_sg ? {1'b0, big_man} + {1'b0, sml_al}
	                     : big_ge ? {1'b0, big_man - sml_al} : {1'b0, sml_al - big_man};
	wire        fsum_neg = (same_sg || big_ge) ? big_neg : sml_neg;
	wire [5:0]  fsum_lz  = lead_zeros(fsum[35:0]);
	// Rounding carry out of the top is not renormalized
	wire [35:0] fadd_man = fsum[36] ? fsum[36:1] + {35'h0, fsum[0]}
	                     : (fsum_lz == 6'h00) ? fsum[35:0] + {35'h0, aligned[35]}
	                     : 36'(fsum[35:0] << fsum_lz);
	wire [10:0] fadd_exp = fsum[36] ? big_exp + 11'h001 : big_exp - {5'h00, fsum_lz};
	wire [47:0] fadd_raw = (fsum == 37'h0) ? 48'h0 : {1'b0, fadd_exp, fadd_man};
	wire [47:0] fadd     = fsum_neg ? ~fadd_raw : fadd_raw;

	// float product, low 36 bits kept unnormalized
	wire [71:0] fprod    = 72'(fa_man * fb_man);
	wire [35:0] fmul_man = fprod[71] ? fprod[71:36] + {35'h0, fprod[35]}
	                     : fprod[70:35] + {35'h0, fprod[34]};
	wire [10:0] fmul_exp = fa_exp + fb_exp - ssalu_pkg::EXP_BIAS - {10'h000, ~fprod[71]};
	wire [47:0] fmul_raw = (fprod == 72'h0) ? 48'h0 : {1'b0, fmul_exp, fmul_man};
	wire [47:0] fmul     = (fa_neg ^ fb_neg) ? ~fmul_raw : fmul_raw;

	// Divider shared by the three divide forms
	wire        is_div1  = op_in == ssalu_pkg::OP_SINGLE_DIV;
	wire        is_div2  = op_in == ssalu_pkg::OP_DOUBLE_DIV;
	wire        is_fdiv  = op_in == ssalu_pkg::OP_FLOAT_DIV;
	wire        pre_fault = is_div1 ? (mem_mag == 24'h000000)
	                      : is_div2 ? (m48_mag == 48'h0) : ~fb_man[35];
	wire        div_go   = go && (is_div1 || is_div2 || is_fdiv) && !pre_fault;
	wire [95:0] dvd      = is_div1 ? {48'h0, pair_mag} : is_div2 ? trip_mag
	                     : {24'h000000, fa_man, 36'h0};
	wire [47:0] dvs      = is_div1 ? {24'h000000, mem_mag} : is_div2 ? m48_mag
	                     : {12'h000, fb_man};
	wire        div_done;
	wire [95:0] quot;
	wire [47:0] rem;
	magnitude_divider #(.W(48)) divider (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.start_in    (div_go),
		.dividend_in (dvd),
		.divisor_in  (dvs),
		.busy_out    (),
		.done_out    (div_done),
		.quot_out    (quot),
		.rem_out     (rem)
	);
	// Quotient too wide for its register is a fault
	wire        q_over   = (op_ff == ssalu_pkg::OP_SINGLE_DIV) ? (quot[95:23] != 73'h0)
	                     : (op_ff == ssalu_pkg::OP_DOUBLE_DIV) ? (quot[95:47] != 49'h0)
	                     : 1'b0;
	wire [23:0] q1       = qneg_ff ? ~{1'b0, quot[22:0]} : {1'b0, quot[22:0]};
	wire [23:0] r1       = rneg_ff ? ~{1'b0, rem[22:0]} : {1'b0, rem[22:0]};
	wire [47:0] q2       = qneg_ff ? ~{1'b0, quot[46:0]} : {1'b0, quot[46:0]};
	wire [47:0] r2       = rneg_ff ? ~{1'b0, rem[46:0]} : {1'b0, rem[46:0]};
	wire [35:0] fq_man   = quot[36] ? quot[36:1] : quot[35:0];
	wire [10:0] fq_exp   = fexp_ff + {10'h000, quot[36]};
	wire [47:0] fq_raw   = (fq_man == 36'h0) ? 48'h0 : {1'b0, fq_exp, fq_man};
	wire [47:0] fq       = qneg_ff ? ~fq_raw : fq_raw;

	// immediate operand, zero or sign extended
	wire [23:0] y_ext    = desig_in[1] ? {9'h000, field_in} : k_sext;
	wire        is_xor   = op_in == ssalu_pkg::OP_XOR_IMMEDIATE;
	wire [23:0] lg_acc   = is_xor ? acc_ff ^ y_ext : acc_ff & y_ext;
	wire [23:0] lg_aux   = is_xor ? aux_ff ^ y_ext : aux_ff & y_ext;
	wire [14:0] lg_idx   = is_xor ? idx_sel ^ field_in : idx_sel & field_in;
	wire        lg_to_q  = desig_in == ssalu_pkg::DESIG_AUX_SEXT
	                     || desig_in == ssalu_pkg::DESIG_AUX_ZEXT;

	// Scale step and residue
	// stop once the top two bits differ
	wire        scl_stop = (pair[47] != pair[46]) || (cnt_ff == ssalu_pkg::SCALE_LIMIT);
	wire [23:0] residue  = oc_add24(k_ff, ~{18'h00000, cnt_ff});

	// Next-state and register update selection
	always_comb begin
		nxt_state      = state_ff;
		nxt_acc        = acc_ff;
		nxt_aux        = aux_ff;
		nxt_ext        = ext_ff;
		nxt_idx        = idx_ff;
		nxt_cnt        = cnt_ff;
		nxt_op         = op_ff;
		nxt_b          = b_ff;
		nxt_k          = k_ff;
		nxt_qneg       = qneg_ff;
		nxt_rneg       = rneg_ff;
		nxt_fexp       = fexp_ff;
		nxt_done       = 1'b0;
		nxt_fault      = 1'b0;
		nxt_store      = 1'b0;
		nxt_store_data = store_data_ff;
		case (state_ff)
			ssalu_pkg::ST_IDLE: begin
				if (start_in) begin
					nxt_done = 1'b1;
					nxt_op   = op_in;
					case (op_in)
						ssalu_pkg::OP_SHIFT_SINGLE: begin
							if (desig_in[2]) nxt_aux = sh_one;
							else nxt_acc = sh_one;
						end
						ssalu_pkg::OP_SHIFT_PAIR: begin
							if (desig_in[2]) begin
								nxt_done  = 1'b0;
								nxt_state = ssalu_pkg::ST_SCALE;
								nxt_cnt   = 6'h00;
								nxt_b     = bsel;
								nxt_k     = k_sext;
							end else begin
								{nxt_acc, nxt_aux} = sh_two;
							end
						end
						ssalu_pkg::OP_XOR_IMMEDIATE, ssalu_pkg::OP_AND_IMMEDIATE: begin
							if (!desig_in[2]) begin
								if (bsel != 2'h0) nxt_idx[bidx] = lg_idx;
							end else if (lg_to_q) nxt_aux = lg_aux;
							else nxt_acc = lg_acc;
						end
						ssalu_pkg::OP_ADD_ACC: nxt_acc = sum_acc;
						ssalu_pkg::OP_SUB_ACC: nxt_acc = diff_acc;
						ssalu_pkg::OP_DOUBLE_ADD: {nxt_acc, nxt_aux} = sum_pair;
						ssalu_pkg::OP_DOUBLE_SUB: {nxt_acc, nxt_aux} = dif_pair;
						ssalu_pkg::OP_REPLACE_ADD: begin
							nxt_store      = 1'b1;
							nxt_store_data = sum_acc;
						end
						// high half auxiliary, low half accumulator
						ssalu_pkg::OP_SINGLE_MUL: {nxt_aux, nxt_acc} = mul1;
						ssalu_pkg::OP_DOUBLE_MUL: {nxt_acc, nxt_aux, nxt_ext} = mul2;
						ssalu_pkg::OP_FLOAT_ADD, ssalu_pkg::OP_FLOAT_SUB: begin
							{nxt_acc, nxt_aux} = fadd;
							nxt_ext = {aligned[35:0], 12'h000};
						end
						ssalu_pkg::OP_FLOAT_MUL: begin
							{nxt_acc, nxt_aux} = fmul;
							nxt_ext = {fprod[35:0], 12'h000};
						end
						ssalu_pkg::OP_SINGLE_DIV, ssalu_pkg::OP_DOUBLE_DIV,
						ssalu_pkg::OP_FLOAT_DIV: begin
							nxt_qneg = is_div1 ? pair[47] ^ oper_hi_in[23]
							         : is_div2 ? trip[95] ^ mem48[47] : fa_neg ^ mem48[47];
							nxt_rneg = is_div2 ? trip[95] : pair[47];
							nxt_fexp = fa_exp - fb_exp + ssalu_pkg::EXP_BIAS;
							// fault ends at once, registers untouched
							if (pre_fault) begin
								nxt_fault = 1'b1;
							end else begin
								nxt_done  = 1'b0;
								nxt_state = ssalu_pkg::ST_DIVIDE;
							end
						end
						default: nxt_done = 1'b1;
					endcase
				end else if (preload_in) begin
					case (preload_sel_in)
						ssalu_pkg::SEL_ACC:    nxt_acc = preload_data_in;
						ssalu_pkg::SEL_AUX:    nxt_aux = preload_data_in;
						ssalu_pkg::SEL_EXT_HI: nxt_ext[47:24] = preload_data_in;
						ssalu_pkg::SEL_EXT_LO: nxt_ext[23:0] = preload_data_in;
						ssalu_pkg::SEL_IDX1:   nxt_idx[0] = preload_data_in[14:0];
						ssalu_pkg::SEL_IDX2:   nxt_idx[1] = preload_data_in[14:0];
						ssalu_pkg::SEL_IDX3:   nxt_idx[2] = preload_data_in[14:0];
						default:               nxt_acc = acc_ff;
					endcase
				end
			end
			ssalu_pkg::ST_SCALE: begin
				// zero pair runs to the 48-place limit
				if (scl_stop) begin
					nxt_state = ssalu_pkg::ST_IDLE;
					nxt_done  = 1'b1;
					// residue to index when designator bits 1-0 nonzero
					if (b_ff != 2'h0) nxt_idx[2'(b_ff - 2'h1)] = residue[14:0];
				end else begin
					{nxt_acc, nxt_aux} = {pair[46:0], pair[47]};
					nxt_cnt = cnt_ff + 6'h01;
				end
			end
			ssalu_pkg::ST_DIVIDE: begin
				if (div_done) begin
					nxt_state = ssalu_pkg::ST_IDLE;
					nxt_done  = 1'b1;
					// overflow reported as a one-cycle event
					nxt_fault = q_over;
					if (op_ff == ssalu_pkg::OP_SINGLE_DIV) begin
						// quotient to accumulator, remainder to auxiliary
						nxt_acc = q1;
						nxt_aux = r1;
					end else if (op_ff == ssalu_pkg::OP_DOUBLE_DIV) begin
						// quotient to pair, remainder to extension
						{nxt_acc, nxt_aux} = q2;
						nxt_ext = r2;
					end else begin
						{nxt_acc, nxt_aux} = fq;
						nxt_ext = r2;
					end
				end
			end
			default: nxt_state = ssalu_pkg::ST_IDLE;
		endcase
	end

	// State and working registers
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_ff <= ssalu_pkg::ST_IDLE;
			acc_ff   <= ssalu_pkg::WORD_RST;
			aux_ff   <= ssalu_pkg::WORD_RST;
			ext_ff   <= ssalu_pkg::EXT_RST;
			idx_ff   <= '{ssalu_pkg::IDX_RST, ssalu_pkg::IDX_RST, ssalu_pkg::IDX_RST};
			cnt_ff   <= 6'h00;
			op_ff    <= 6'h00;
			b_ff     <= 2'h0;
			k_ff     <= ssalu_pkg::WORD_RST;
		end else begin
			state_ff <= nxt_state;
			acc_ff   <= nxt_acc;
			aux_ff   <= nxt_aux;
			ext_ff   <= nxt_ext;
			idx_ff   <= nxt_idx;
			cnt_ff   <= nxt_cnt;
			op_ff    <= nxt_op;
			b_ff     <= nxt_b;
			k_ff     <= nxt_k;
		end
	end

	// Divide context and reply strobes
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			qneg_ff       <= 1'b0;
			rneg_ff       <= 1'b0;
			fexp_ff       <= 11'h000;
			busy_ff       <= 1'b0;
			done_ff       <= 1'b0;
			fault_ff      <= 1'b0;
			store_ff      <= 1'b0;
			store_data_ff <= ssalu_pkg::WORD_RST;
		end else begin
			qneg_ff       <= nxt_qneg;
			rneg_ff       <= nxt_rneg;
			fexp_ff       <= nxt_fexp;
			// Busy from the next state so the port is a plain flop
			busy_ff       <= nxt_state != ssalu_pkg::ST_IDLE;
			done_ff       <= nxt_done;
			fault_ff      <= nxt_fault;
			store_ff      <= nxt_store;
			store_data_ff <= nxt_store_data;
		end
	end

	// Outputs straight from registers
	assign busy_out        = busy_ff;
	assign done_out        = done_ff;
	assign div_fault_out   = fault_ff;
	assign store_valid_out = store_ff;
	assign store_data_out  = store_data_ff;
	assign acc_out         = acc_ff;
	assign aux_out         = aux_ff;
	assign ext_out         = ext_ff;
	assign idx1_out        = idx_ff[0];
	assign idx2_out        = idx_ff[1];
	assign idx3_out        = idx_ff[2];
endmodule : shift_scale_arith_logic_unit

//--- testbench/alu_asserts.sv
`timescale 1ns/10ps
module alu_asserts (
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	// Request side
	input wire logic        start_in,
	input wire logic [5:0]  op_in,
	input wire logic [2:0]  desig_in,
	input wire logic [14:0] field_in,
	input wire logic [23:0] oper_hi_in,
	// Answer side
	input wire logic        busy_out,
	input wire logic        done_out,
	input wire logic        div_fault_out,
	input wire logic        store_valid_out,
	input wire logic [23:0] store_data_out,
	input wire logic [23:0] acc_out
);
	// Sum with end-around carry
	function automatic logic [23:0] oc(input logic [23:0] a, input logic [23:0] b);
		logic [24:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[23:0] + {23'h0, s[24]};
	endfunction : oc
	// Accepted request, start ignored while busy
	wire tk = start_in && !busy_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_add_sum: assert property (tk && op_in == ssalu_pkg::OP_ADD_ACC |=> done_out &&
		acc_out == oc($past(acc_out), $past(oper_hi_in))) else $error("add sum");
	chk_sub_diff: assert property (tk && op_in == ssalu_pkg::OP_SUB_ACC |=>
		acc_out == oc($past(acc_out), ~$past(oper_hi_in))) else $error("difference");
	chk_replace_keep: assert property (tk && op_in == ssalu_pkg::OP_REPLACE_ADD |=>
		store_valid_out && $stable(acc_out) &&
		store_data_out == oc($past(acc_out), $past(oper_hi_in))) else $error("write-back");
	chk_xor_zext: assert property (tk && op_in == ssalu_pkg::OP_XOR_IMMEDIATE &&
		desig_in == ssalu_pkg::DESIG_ACC_ZEXT |=>
		acc_out == ($past(acc_out) ^ {9'h0, $past(field_in)})) else $error("xor");
	chk_rotate_full: assert property (tk && op_in == ssalu_pkg::OP_SHIFT_SINGLE &&
		desig_in == 3'h0 && field_in == 15'h0018 |=> done_out && $stable(acc_out))
		else $error("full rotate");
	chk_scale_bound: assert property (tk && op_in == ssalu_pkg::OP_SHIFT_PAIR &&
		desig_in[2] |=> busy_out ##[1:49] done_out) else $error("scale length");
	chk_div_bound: assert property (tk && (op_in == ssalu_pkg::OP_SINGLE_DIV ||
		op_in == ssalu_pkg::OP_DOUBLE_DIV) |-> ##[1:99] done_out) else $error("divide");
	chk_fault_done: assert property (div_fault_out |-> done_out && !busy_out)
		else $error("fault alone");
endmodule : alu_asserts
bind shift_scale_arith_logic_unit alu_asserts alu_asserts_inst (.*);

//--- testbench/storage_model.sv
`timescale 1ns/10ps
module storage_model (
	// Access
	input  wire logic        clk_in,
	input  wire logic        req_in,
	input  wire logic [1:0]  addr_in,
	input  wire logic        store_valid_in,
	input  wire logic [23:0] store_data_in,
	// Words at M and M+1
	output logic      [23:0] word_hi_out,
	output logic      [23:0] word_lo_out
);
	logic [23:0] mem [4] = '{24'h000003, 24'h000005, 24'h000002, 24'h000000};
	// M and M+1; garbage when not asked
	assign word_hi_out = req_in ? mem[addr_in] : ~mem[addr_in];
	assign word_lo_out = req_in ? mem[addr_in + 2'h1] : ~mem[addr_in + 2'h1];
	always @(posedge clk_in) if (store_valid_in) mem[addr_in] <= store_data_in;
endmodule : storage_model

//--- testbench/shift_scale_arith_logic_unit_bench.sv
`timescale 1ns/10ps
module shift_scale_arith_logic_unit_bench;
	// Driven inputs
	logic        clk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, preload_in = 1'b0;
	logic [5:0]  op_in = 6'h00;
	logic [2:0]  desig_in = 3'h0, preload_sel_in = 3'h0;
	logic [14:0] field_in = 15'h0000;
	logic [23:0] preload_data_in = 24'h000000, oper_hi_in, oper_lo_in;
	logic [1:0]  addr = 2'h0;
	// Observed outputs
	logic        busy_out, done_out, div_fault_out, store_valid_out, flt;
	logic [23:0] store_data_out, acc_out, aux_out;
	logic [47:0] ext_out;
	logic [14:0] idx1_out, idx2_out, idx3_out;
	int          n_errors = 0, samples_checked = 0;
	// Clock
	always #20 clk_in = ~clk_in;
	shift_scale_arith_logic_unit shift_scale_arith_logic_unit_inst (.*);
	storage_model storage_model_inst (.clk_in, .req_in(start_in), .addr_in(addr),
		.store_valid_in(store_valid_out), .store_data_in(store_data_out),
		.word_hi_out(oper_hi_in), .word_lo_out(oper_lo_in));
	task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : cmp
	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// Preload only while idle and not starting
	task automatic ld(input logic [2:0] s, input logic [23:0] d);
		@(posedge clk_in);
		preload_in <= 1'b1;
		preload_sel_in <= s;
		preload_data_in <= d;
		@(posedge clk_in);
		preload_in <= 1'b0;
	endtask : ld
	// One-cycle start, then bounded wait for done at falling edges
	task automatic go(input logic [5:0] o, input logic [2:0] d, input logic [14:0] f,
		input logic [1:0] a);
		int i;
		@(posedge clk_in);
		start_in <= 1'b1;
		op_in <= o;
		desig_in <= d;
		field_in <= f;
		addr <= a;
		@(posedge clk_in);
		start_in <= 1'b0;
		for (i = 0; i < 120; i++) begin
			@(negedge clk_in);
			if (done_out === 1'b1) break;
		end
		flt = div_fault_out;
		if (i == 120) begin
			n_errors++;
			wrap_up();
		end
	endtask : go
	task automatic t_fixed;
		ld(3'h1, 24'h00000f);
		go(6'h29, 3'h0, 15'h0, 2'h1);
		cmp("quot", 48'h000003000000, {acc_out, aux_out});
		go(6'h29, 3'h0, 15'h0, 2'h3);
		cmp("fault", 48'h1, 48'(flt));
		go(6'h18, 3'h0, 15'h0, 2'h0);
		cmp("add", 48'h6, 48'(acc_out));
		go(6'h19, 3'h0, 15'h0, 2'h0);
		cmp("sub", 48'h3, 48'(acc_out));
		go(6'h1c, 3'h0, 15'h0, 2'h2);
		cmp("store", 48'h000003000005, {acc_out, store_data_out});
		go(6'h28, 3'h0, 15'h0, 2'h1);
		cmp("mul", 48'h00000000000f, {aux_out, acc_out});
	endtask : t_fixed
	task automatic t_logic_shift;
		go(6'h0e, 3'h4, 15'h40f0, 2'h0);
		cmp("xor", 48'hffc0ff, 48'(acc_out));
		go(6'h0f, 3'h4, 15'h7f0f, 2'h0);
		cmp("and", 48'hffc00f, 48'(acc_out));
		go(6'h0a, 3'h0, 15'h7ff9, 2'h0);
		cmp("shr", 48'hffff00, 48'(acc_out));
		go(6'h0a, 3'h0, 15'h0018, 2'h0);
		cmp("rot", 48'hffff00, 48'(acc_out));
		ld(3'h4, 24'h000002);
		ld(3'h1, 24'h800001);
		go(6'h0a, 3'h5, 15'h0001, 2'h0);
		cmp("shq", 48'h00000c, 48'(aux_out));
	endtask : t_logic_shift
	task automatic t_scale;
		go(6'h0b, 3'h5, 15'h0010, 2'h0);
		cmp("scl", 48'h800000067fff, {acc_out, aux_out});
		cmp("res", 48'h1, 48'(idx1_out));
		ld(3'h0, 24'h000000);
		ld(3'h1, 24'h000000);
		go(6'h0b, 3'h6, 15'h0000, 2'h0);
		cmp("zres", 48'h7fcf, 48'(idx2_out));
	endtask : t_scale
	// Pair, double and index forms; storage word 2 holds the replace-add sum
	task automatic t_double;
		go(6'h18, 3'h0, 15'h0, 2'h2);
		cmp("wback", 48'h5, 48'(acc_out));
		go(6'h0e, 3'h6, 15'h4001, 2'h0);
		cmp("xorz", 48'h004004, 48'(acc_out));
		go(6'h2e, 3'h0, 15'h0, 2'h3);
		cmp("dmul", 48'h00c00c000000, ext_out);
		cmp("dmulhi", 48'h0, {acc_out, aux_out});
		go(6'h2f, 3'h0, 15'h0, 2'h3);
		cmp("ddiv", 48'h004004000000, {acc_out, aux_out});
		cmp("drem", 48'h0, ext_out);
		go(6'h33, 3'h0, 15'h0, 2'h0);
		cmp("fdiv", 48'h1, 48'(flt));
		go(6'h0e, 3'h3, 15'h0031, 2'h0);
		cmp("xori", 48'h31, 48'(idx3_out));
		go(6'h0b, 3'h3, 15'h0000, 2'h0);
		cmp("lpair", 48'h008008000000, {acc_out, aux_out});
		go(6'h0b, 3'h0, 15'h7ffb, 2'h0);
		cmp("rpair", 48'h000800800000, {acc_out, aux_out});
		go(6'h1a, 3'h0, 15'h0, 2'h0);
		cmp("dadd", 48'h000803800005, {acc_out, aux_out});
		go(6'h1b, 3'h0, 15'h0, 2'h0);
		cmp("dsub", 48'h000800800000, {acc_out, aux_out});
	endtask : t_double
	// Reset for 20 cycles, then the scenarios
	initial begin
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_fixed();
		t_logic_shift();
		t_scale();
		t_double();
		wrap_up();
	end
endmodule : shift_scale_arith_logic_unit_bench
